// File: sim/servo_checker_assertions.sv
/*
 * Port checks for the servo block, bound from the bench.
 * Assumes inputs change on the falling edge of clock.
 */
`timescale 1ns/100ps
`default_nettype none
module servo_checker #(
    parameter CNT_W = 16,
    parameter RUN_W = 8
)(
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Inputs
    input wire logic drum_speed_pulse_in,
    input wire logic drum_phase_pulse_in,
    input wire logic capstan_speed_pulse_in,
    input wire logic playback_track_input,
    input wire logic head_switch_external,
    input wire logic special_playback,
    input wire logic [CNT_W-1:0] head_delay,
    input wire logic [CNT_W-1:0] fsync_high_len,
    // Outputs
    input wire logic head_switch_pin_oe,
    input wire logic head_switch_timing_pulse,
    input wire logic false_sync_output,
    input wire logic false_sync_oe,
    input wire logic index_search_detector,
    input wire logic head_amp_switch_out,
    input wire logic chroma_rotation_switch_out,
    input wire logic [CNT_W-1:0] drum_speed_error,
    input wire logic [CNT_W-1:0] drum_phase_error,
    input wire logic [CNT_W-1:0] capstan_speed_error,
    input wire logic [RUN_W-1:0] run_count_latch
);
    // ------------------------------------------------------------------------
    // Input history
    // ------------------------------------------------------------------------
    // Three samples allow one cycle of slack in where the latch lands.
    logic [11:0] hist_r;
    logic [CNT_W:0] hi_cnt_r;
    logic [CNT_W:0] since_pg_r;
    wire logic [3:0] rose_n = (hist_r[3:0] & ~hist_r[7:4]) | (hist_r[7:4] & ~hist_r[11:8]);
    wire logic tk_fell = (~hist_r[3] & hist_r[7]) | (~hist_r[7] & hist_r[11]);
    always @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            hist_r <= 12'h000;
            hi_cnt_r <= '0;
            since_pg_r <= '0;
        end
        else
        begin
            hist_r <= {hist_r[7:0], playback_track_input, capstan_speed_pulse_in,
                       drum_phase_pulse_in, drum_speed_pulse_in};
            hi_cnt_r <= (false_sync_oe && false_sync_output) ? hi_cnt_r + 1'b1 : '0;
            since_pg_r <= (drum_phase_pulse_in && !hist_r[1]) ? '0 : since_pg_r + 1'b1;
        end
    end
    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    a_drum_speed_hold: assert property ($changed(drum_speed_error) |-> rose_n[0])
        else $error("drum speed error moved without its edge");
    a_drum_phase_hold: assert property ($changed(drum_phase_error) |-> rose_n[1])
        else $error("drum phase error moved without its edge");
    a_cap_speed_hold: assert property ($changed(capstan_speed_error) |-> rose_n[2])
        else $error("capstan speed error moved without its edge");
    a_run_latch_hold: assert property ($changed(run_count_latch) |-> tk_fell)
        else $error("run latch moved without a track fall");
    a_index_on_fall: assert property ($changed(index_search_detector) |-> tk_fell)
        else $error("index output moved without a track fall");
    a_pin_oe_mode: assert property ($past(resetn) |->
        head_switch_pin_oe == !$past(head_switch_external))
        else $error("head pin enable does not follow the mode");
    a_amp_gated: assert property (!$past(special_playback) |->
        !head_amp_switch_out && !chroma_rotation_switch_out)
        else $error("switch outputs active outside special playback");
    a_fsync_high_len: assert property (false_sync_oe && $fell(false_sync_output) |->
        hi_cnt_r == fsync_high_len + 1'b1)
        else $error("false sync high phase has the wrong length");
    a_head_delay: assert property (!head_switch_external && $rose(head_switch_timing_pulse) |->
        since_pg_r == head_delay + 1'b1)
        else $error("head pulse delay is wrong");
    c_head_rise: cover property ($rose(head_switch_timing_pulse));
    c_fsync_fall: cover property (false_sync_oe && $fell(false_sync_output));
    c_run_latch: cover property ($changed(run_count_latch));
endmodule // servo_checker
`default_nettype wire

// File: sim/servo_motor_model.sv
/*
 * Drum, capstan and tape sensors seen by the servo block.
 * Assumes one system clock; every pulse is timed on its falling edge.
 */
`timescale 1ns/100ps
`default_nettype none
module servo_motor_model (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Ones recorded before each zero on the track
    input wire logic [3:0] ones_per_run,
    // Sensor pulses
    output wire logic drum_speed_pulse_in,
    output wire logic drum_phase_pulse_in,
    output wire logic capstan_speed_pulse_in,
    output wire logic playback_track_input,
    output wire logic vsync_in,
    output wire logic ref_tick
);
    logic [10:0] t_r;
    logic [3:0] pos_r;
    always @(negedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            t_r <= 11'h000;
            pos_r <= 4'h0;
        end
        else
        begin
            t_r <= (t_r == 11'd1199) ? 11'h000 : t_r + 1'b1;
            if (t_r % 100 == 99)
                pos_r <= (pos_r == ones_per_run) ? 4'h0 : pos_r + 1'b1;
        end
    end
    assign drum_speed_pulse_in = (t_r % 200) < 2;
    assign drum_phase_pulse_in = (t_r % 400) == 50;
    assign capstan_speed_pulse_in = (t_r % 120) < 2;
    assign vsync_in = (t_r % 400) < 2;
    assign ref_tick = (t_r % 4) == 0;
    assign playback_track_input = (t_r % 100) < ((pos_r == ones_per_run) ? 30 : 70);
endmodule // servo_motor_model
`default_nettype wire

// File: sim/tb_vcr_servo_controller.sv
/*
 * Self-checking bench for the servo block with the motor model.
 * Assumes the defines header, checker and model are compiled alongside.
 */
`include "servo_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_vcr_servo_controller;
    localparam int FRAME = `PWM_SUBS * 128 * `PWM_DIV;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic phase_ref_sel_vsync = 1'b1;
    logic cap_phase_sel_track = 1'b0;
    logic head_switch_external = 1'b0;
    logic special_playback = 1'b0;
    logic hsw_drive = 1'b0;
    logic [7:0] cap_phase_div = 8'h03;
    logic [3:0] ones_per_run = 4'h5;
    logic [15:0] head_delay = 16'h000a, fsync_high_len = 16'h0009;
    logic [15:0] fsync_low_len = 16'h0013, duty_threshold = 16'h0032;
    logic [9:0] row_val [4] = '{10'h000, 10'h001, 10'h155, 10'h3ff};
    wire logic [4*`PWM_W-1:0] pwm_value = {row_val[3], row_val[2], row_val[1], row_val[0]};
    wire logic ref_tick, vsync_in, drum_speed_pulse_in, drum_phase_pulse_in;
    wire logic capstan_speed_pulse_in, playback_track_input, head_switch_pin_in;
    logic head_switch_pin_out, head_switch_pin_oe, false_sync_output, false_sync_oe;
    logic index_search_detector, head_amp_switch_out, chroma_rotation_switch_out;
    logic head_switch_timing_pulse;
    logic [3:0] pwm_out;
    logic [15:0] drum_speed_error, drum_phase_error, capstan_speed_error, capstan_phase_error;
    logic [7:0] run_count_latch;
    int checks = 0, miscompares = 0, cycles = 0;
    int hi_cnt [4] = '{0, 0, 0, 0};
    assign head_switch_pin_in = head_switch_pin_oe ? head_switch_pin_out : hsw_drive;
    vcr_servo_controller dut (.*);
    servo_motor_model motor (.*);
    always #4 clock = ~clock;
    // ------------------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------------------
    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic close_out;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // The whole run needs about 72500 cycles.
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            miscompares++;
            close_out();
        end
    end
    // ------------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------------
    initial
    begin
        repeat (6) @(negedge clock);
        cmp_val("outputs in reset", 32'h0, {pwm_out, false_sync_output, false_sync_oe,
            head_switch_timing_pulse, drum_speed_error, run_count_latch});
        resetn = 1'b1;
        $display("test reset done");
        // A frame is skipped first so the values are surely latched at a frame start.
        repeat (FRAME) @(negedge clock);
        repeat (FRAME)
        begin
            @(negedge clock);
            for (int i = 0; i < 4; i++)
                hi_cnt[i] += pwm_out[i];
        end
        for (int i = 0; i < 4; i++)
            cmp_val("pwm high cycles", row_val[i] * `PWM_DIV, hi_cnt[i]);
        $display("test pwm done");
        cmp_val("drum speed error", 32'd50, drum_speed_error);
        cmp_val("capstan speed error", 32'd30, capstan_speed_error);
        cmp_val("drum phase error", 32'd50, drum_phase_error);
        cmp_val("run length", ones_per_run, run_count_latch);
        $display("test sensors done");
        special_playback = 1'b1;
        phase_ref_sel_vsync = 1'b0;
        cap_phase_sel_track = 1'b1;
        head_switch_external = 1'b1;
        repeat (2) @(negedge clock);
        cmp_val("head pin enable", 32'h0, head_switch_pin_oe);
        repeat (6)
        begin
            repeat (150) @(negedge clock);
            hsw_drive = ~hsw_drive;
        end
        head_switch_external = 1'b0;
        phase_ref_sel_vsync = 1'b1;
        repeat (2) @(negedge clock);
        cmp_val("head pin enable", 32'h1, head_switch_pin_oe);
        repeat (2000) @(negedge clock);
        cmp_val("drum phase error", 32'd50, drum_phase_error);
        $display("test head modes done");
        close_out();
    end
endmodule // tb_vcr_servo_controller
bind vcr_servo_controller servo_checker #(.CNT_W(CNT_W), .RUN_W(RUN_W)) u_chk (.*);
`default_nettype wire

// File: src/servo_defines.vh
/*
 * Constants for the VCR servo controller: widths, reset values, timing.
 * Assumes inclusion by bare name from the servo design file.
 */
`ifndef SERVO_DEFINES_VH
`define SERVO_DEFINES_VH
// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define CNT_W 16
`define CNT_RST 16'h0000
`define PWM_W 10
`define PWM_COARSE_W 7
`define PWM_FINE_W 3
`define PWM_SUBS 8
`define PWM_CH 4
`define RUN_W 8
// ----------------------------------------------------------------------------
// Timing: PWM count clock is the colour-subcarrier rate in kHz.
// ----------------------------------------------------------------------------
`define PWM_CLK_KHZ 3580
`define SYS_CLK_KHZ 125000
`define PWM_DIV ((`SYS_CLK_KHZ) / (`PWM_CLK_KHZ))
`define FSYNC_HIGH 2'h0
`define FSYNC_LOW 2'h1
`define FSYNC_HIZ 2'h2
`endif

// File: src/vcr_servo_controller.v
/*
 * Servo block of a video-recorder controller: speed and phase comparators,
 * head switching pulse with delay, false sync, dithered PWM, track duty
 * classifier and run counter.
 * Assumes all inputs synchronous to clock and the CPU side driving the
 * configuration ports as stable levels.
 */
`include "servo_defines.vh"
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Drum speed pulse interval counted on reference clock, latched as speed error.
// - Drum phase pulse timed against vertical sync or reference clock, selectable.
// - Capstan speed pulse interval counted on reference clock, latched error.
// - Head switch compared to divided track or capstan speed pulse.
// - Head switch pulse set by drum phase pulse, cleared by the next drum speed pulse.
// - Head switch output delayed by programmed count through one-shot timer.
// - False sync drives high, low, high-impedance intervals from both head edges.
// - Four PWM channels, assignable by software to loops.
// - Each PWM value is 10 bits: 7 coarse, 3 fine.
// - Frame of eight sub-periods; fine value extends that many by one.
// - Sub-period repeats about 28 kHz at 3.579545 MHz count clock.
// - Each track pulse classified one or zero by duty ratio.
// - Consecutive ones counted and latched for CPU reading.
// - Duty classification driven onto index search pin.
// - Head amp and chroma switch outputs during special playback.
// - Head switch pin outputs generated signal or accepts external pulse.
module vcr_servo_controller #(
    parameter CNT_W = `CNT_W,
    parameter RUN_W = `RUN_W
)(
    // Clock and reset
    input wire clock,
    input wire resetn,
    // Sensor inputs
    input wire drum_speed_pulse_in,
    input wire drum_phase_pulse_in,
    input wire capstan_speed_pulse_in,
    input wire playback_track_input,
    input wire vsync_in,
    input wire ref_tick,
    // Head switch pin, three signals
    input wire head_switch_pin_in,
    output reg head_switch_pin_out,
    output reg head_switch_pin_oe,
    // Configuration from the CPU
    input wire phase_ref_sel_vsync,
    input wire cap_phase_sel_track,
    input wire [7:0] cap_phase_div,
    input wire head_switch_external,
    input wire [CNT_W-1:0] head_delay,
    input wire [CNT_W-1:0] fsync_high_len,
    input wire [CNT_W-1:0] fsync_low_len,
    input wire [CNT_W-1:0] duty_threshold,
    input wire special_playback,
    input wire [4*`PWM_W-1:0] pwm_value,
    // Status to the CPU
    output reg [CNT_W-1:0] drum_speed_error,
    output reg [CNT_W-1:0] drum_phase_error,
    output reg [CNT_W-1:0] capstan_speed_error,
    output reg [CNT_W-1:0] capstan_phase_error,
    output reg [RUN_W-1:0] run_count_latch,
    // Pins
    output reg head_switch_timing_pulse,
    output reg false_sync_output,
    output reg false_sync_oe,
    output reg [`PWM_CH-1:0] pwm_out,
    output reg index_search_detector,
    output reg head_amp_switch_out,
    output reg chroma_rotation_switch_out
);
// ----------------------------------------------------------------------------
// Edge detection
// ----------------------------------------------------------------------------
reg dfg_d_r, dpg_d_r, cfg_d_r, trk_d_r, vs_d_r, hsw_d_r, cpg_d_r;
wire dfg_rise = drum_speed_pulse_in & ~dfg_d_r;
wire dpg_rise = drum_phase_pulse_in & ~dpg_d_r;
wire cfg_rise = capstan_speed_pulse_in & ~cfg_d_r;
wire trk_rise = playback_track_input & ~trk_d_r;
wire trk_fall = ~playback_track_input & trk_d_r;
wire vs_rise = vsync_in & ~vs_d_r;
reg [CNT_W-1:0] dfg_cnt_r, dpg_cnt_r, cfg_cnt_r, cpg_cnt_r, trk_cnt_r;
reg [7:0] div_cnt_r;
reg cpg_r;
reg hsp_raw_r;
wire hsw_sel = head_switch_external ? head_switch_pin_in : head_switch_timing_pulse;
wire hsw_edge = hsw_sel ^ hsw_d_r;
wire div_src = cap_phase_sel_track ? trk_rise : cfg_rise;
wire phase_ref = phase_ref_sel_vsync ? vs_rise : ref_tick;

function [CNT_W-1:0] inc_sat;
    input [CNT_W-1:0] v;
    begin
        inc_sat = (&v) ? v : v + 1'b1;
    end
endfunction
// ----------------------------------------------------------------------------
// Comparators
// ----------------------------------------------------------------------------
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        {dfg_d_r, dpg_d_r, cfg_d_r, trk_d_r, vs_d_r, hsw_d_r, cpg_d_r} <= 7'h00;
        dfg_cnt_r <= `CNT_RST; dpg_cnt_r <= `CNT_RST; cfg_cnt_r <= `CNT_RST;
        cpg_cnt_r <= `CNT_RST;
        drum_speed_error <= `CNT_RST; drum_phase_error <= `CNT_RST;
        capstan_speed_error <= `CNT_RST; capstan_phase_error <= `CNT_RST;
        div_cnt_r <= 8'h00;
        cpg_r <= 1'b0;
    end
    else
    begin
        dfg_d_r <= drum_speed_pulse_in;
        dpg_d_r <= drum_phase_pulse_in;
        cfg_d_r <= capstan_speed_pulse_in;
        trk_d_r <= playback_track_input;
        vs_d_r <= vsync_in;
        hsw_d_r <= hsw_sel;
        cpg_d_r <= cpg_r;
        // Interval counts advance on reference ticks; errors latch at the edge.
        if (dfg_rise)
        begin
            // A tick that lands on the edge still belongs to the closing interval.
            drum_speed_error <= ref_tick ? inc_sat(dfg_cnt_r) : dfg_cnt_r;
            dfg_cnt_r <= `CNT_RST;
        end
        else if (ref_tick)
            dfg_cnt_r <= inc_sat(dfg_cnt_r);
        if (cfg_rise)
        begin
            capstan_speed_error <= ref_tick ? inc_sat(cfg_cnt_r) : cfg_cnt_r;
            cfg_cnt_r <= `CNT_RST;
        end
        else if (ref_tick)
            cfg_cnt_r <= inc_sat(cfg_cnt_r);
        // Phase count restarts at the chosen reference and is read at the phase pulse.
        if (dpg_rise)
            drum_phase_error <= dpg_cnt_r;
        // Restarting at one makes the latched value the full cycle distance.
        if (phase_ref)
            dpg_cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
        else
            dpg_cnt_r <= inc_sat(dpg_cnt_r);
        // Divider producing the capstan phase pulse.
        cpg_r <= 1'b0;
        if (div_src)
        begin
            if (div_cnt_r >= cap_phase_div)
            begin
                div_cnt_r <= 8'h00;
                cpg_r <= 1'b1;
            end
            else
                div_cnt_r <= div_cnt_r + 8'h01;
        end
        if (hsw_edge & hsw_sel)
            cpg_cnt_r <= `CNT_RST;
        else
            cpg_cnt_r <= inc_sat(cpg_cnt_r);
        if (cpg_r & ~cpg_d_r)
            capstan_phase_error <= cpg_cnt_r;
    end
end
// ----------------------------------------------------------------------------
// Head switching, delay one-shot, false sync, special playback switches
// ----------------------------------------------------------------------------
reg [CNT_W-1:0] dly_cnt_r, fs_cnt_r;
reg dly_busy_r;
reg [1:0] fs_state_r;
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        hsp_raw_r <= 1'b0; dly_cnt_r <= `CNT_RST; dly_busy_r <= 1'b0;
        head_switch_timing_pulse <= 1'b0;
        head_switch_pin_out <= 1'b0; head_switch_pin_oe <= 1'b0;
        fs_cnt_r <= `CNT_RST; fs_state_r <= `FSYNC_HIZ;
        false_sync_output <= 1'b0; false_sync_oe <= 1'b0;
        head_amp_switch_out <= 1'b0; chroma_rotation_switch_out <= 1'b0;
    end
    else
    begin
        // Speed pulses are counted only implicitly; the revolution pulse sets the head.
        if (dpg_rise)
        begin
            hsp_raw_r <= 1'b1;
            dly_cnt_r <= head_delay;
            dly_busy_r <= 1'b1;
        end
        else if (dfg_rise & hsp_raw_r)
        begin
            hsp_raw_r <= 1'b0;
            dly_cnt_r <= head_delay;
            dly_busy_r <= 1'b1;
        end
        else if (dly_busy_r)
        begin
            if (dly_cnt_r == `CNT_RST)
            begin
                dly_busy_r <= 1'b0;
                head_switch_timing_pulse <= hsp_raw_r;
            end
            else
                dly_cnt_r <= dly_cnt_r - 1'b1;
        end
        head_switch_pin_out <= head_switch_timing_pulse;
        head_switch_pin_oe <= ~head_switch_external;
        // Each head edge starts high, then low, then releases the pin.
        case (fs_state_r)
        `FSYNC_HIGH:
            if (fs_cnt_r >= fsync_high_len)
            begin
                fs_state_r <= `FSYNC_LOW;
                fs_cnt_r <= `CNT_RST;
            end
            else
                fs_cnt_r <= fs_cnt_r + 1'b1;
        `FSYNC_LOW:
            if (fs_cnt_r >= fsync_low_len)
                fs_state_r <= `FSYNC_HIZ;
            else
                fs_cnt_r <= fs_cnt_r + 1'b1;
        default:
            fs_cnt_r <= `CNT_RST;
        endcase
        if (hsw_edge)
        begin
            fs_state_r <= `FSYNC_HIGH;
            fs_cnt_r <= `CNT_RST;
        end
        false_sync_output <= (fs_state_r == `FSYNC_HIGH);
        false_sync_oe <= (fs_state_r != `FSYNC_HIZ);
        head_amp_switch_out <= special_playback & hsw_sel;
        chroma_rotation_switch_out <= special_playback & ~hsw_sel;
    end
end
// ----------------------------------------------------------------------------
// Track duty classifier and run counter
// ----------------------------------------------------------------------------
reg [RUN_W-1:0] run_r;
wire trk_one = trk_cnt_r > duty_threshold;
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        trk_cnt_r <= `CNT_RST; run_r <= {RUN_W{1'b0}};
        run_count_latch <= {RUN_W{1'b0}}; index_search_detector <= 1'b0;
    end
    else
    begin
        if (trk_rise)
            trk_cnt_r <= `CNT_RST;
        else if (playback_track_input)
            trk_cnt_r <= inc_sat(trk_cnt_r);
        if (trk_fall)
        begin
            index_search_detector <= trk_one;
            if (trk_one)
                run_r <= run_r + 1'b1;
            else
            begin
                run_count_latch <= run_r;
                run_r <= {RUN_W{1'b0}};
            end
        end
    end
end
// ----------------------------------------------------------------------------
// PWM: divider enable, coarse counter, sub-period index, frame-latched values
// ----------------------------------------------------------------------------
// Divider makes the count enable; 128 counts per sub-period gives about 28 kHz.
reg [7:0] div_r;
reg [`PWM_COARSE_W-1:0] pcnt_r;
reg [2:0] sub_r;
reg [4*`PWM_W-1:0] pwm_act_r;
integer i;
always @(posedge clock or negedge resetn)
begin
    if (!resetn)
    begin
        div_r <= 8'h00; pcnt_r <= 7'h00; sub_r <= 3'h0;
        pwm_act_r <= 40'h0; pwm_out <= 4'h0;
    end
    else
    begin
        if (div_r >= `PWM_DIV - 1)
        begin
            div_r <= 8'h00;
            pcnt_r <= pcnt_r + 7'h01;
            if (&pcnt_r)
            begin
                sub_r <= sub_r + 3'h1;
                if (&sub_r)
                    pwm_act_r <= pwm_value;
            end
        end
        else
            div_r <= div_r + 8'h01;
        for (i = 0; i < `PWM_CH; i = i + 1)
            pwm_out[i] <= ({1'b0, pcnt_r} < ({1'b0, pwm_act_r[i*10+3 +: 7]}
                + {7'h00, (sub_r < pwm_act_r[i*10 +: 3])}));
    end
end
endmodule // vcr_servo_controller
`default_nettype wire
